// file: adcu_defs.svh
// Offsets, field positions, masks, reset values and timing counts of the upper config bank
`ifndef ADCU_DEFS_SVH
`define ADCU_DEFS_SVH

// Register indices; byte address on the bus is four times the index
`define ADCU_IDX_OFFS_COMP   8'hcf
`define ADCU_IDX_TUNE_A      8'hd4
`define ADCU_IDX_TUNE_B      8'hd5
`define ADCU_IDX_TUNE_C      8'hd6
`define ADCU_IDX_TUNE_D      8'hd7
`define ADCU_IDX_TUNE_E      8'hdb
`define ADCU_IDX_BOOST_SRC   8'hea
`define ADCU_IDX_TUNE_UNADDR 8'hf0
`define ADCU_IDX_SWING       8'hf1
`define ADCU_IDX_TUNE_F      8'hf5
`define ADCU_IDX_CHAN_PDN    8'hfe
`define ADCU_IDX_BOOST_DIS   8'h44

// Writable bits; every other bit is a fixed zero
`define ADCU_MASK_OFFS_COMP   8'h08
`define ADCU_MASK_TUNE_A      8'h80
`define ADCU_MASK_TUNE_B      8'h80
`define ADCU_MASK_TUNE_C      8'h80
`define ADCU_MASK_TUNE_D      8'h0c
`define ADCU_MASK_TUNE_E      8'h30
`define ADCU_MASK_BOOST_SRC   8'h80
`define ADCU_MASK_TUNE_UNADDR 8'h38
`define ADCU_MASK_SWING       8'h23
`define ADCU_MASK_TUNE_F      8'h42
`define ADCU_MASK_CHAN_PDN    8'h0f
`define ADCU_MASK_BOOST_DIS   8'h01

`define ADCU_REG_RESET 8'h00

// Field positions
`define ADCU_BIT_BOOST_SRC  7
`define ADCU_BIT_BOOST_DIS  0
`define ADCU_SWING_HI       1
`define ADCU_SWING_LO       0
`define ADCU_SWING_ON       2'b11
`define ADCU_BIT_PDN_D      3
`define ADCU_BIT_PDN_C      2
`define ADCU_BIT_PDN_A      1
`define ADCU_BIT_PDN_B      0

// Converter timing
`define ADCU_LATENCY_SAMPLES 10

`endif

// file: adcu_pkg.sv
// Types shared by the upper config bank and converter timing model
package adcu_pkg;
	typedef struct packed {
		logic        read;
		logic        write;
		logic [9:0]  address;
		logic [3:0]  byteenable;
		logic [31:0] writedata;
	} adcu_avs_req_s;

	typedef logic [10:0] adcu_sample_t;
	typedef logic [5:0]  adcu_lane_t;
endpackage : adcu_pkg

// file: adcu_top.sv
// Upper configuration register bank and converter output timing of a quad ADC
// Function
// - Tuning bits held at listed positions: one each in D4,D5,D6, two each in D7,DB,F5.
// - Unaddressed register holds three tuning bits at D5, D4 and D3.
// - Boost_source_select_reg D7 zero follows the control pin; one follows register disable.
// - Register disable acts only under override; one turns enhancement off everywhere.
// - Swing field 00 disables, 11 enables swing control; 01 and 10 unused.
// - F1h holds one tuning bit, taken here at position D5.
// - Channel_powerdown D3 powers down channel D, D2 channel C; clear restores.
// - Channel_powerdown D1 powers down channel A, D0 channel B.
// - Every register of the bank resets to all zeros.
// - All four channels are sampled together on each sampling clock fall.
// - Each result appears ten sampling cycles after its sample.
// - Outputs are 11-bit twos complement per channel over DDR lanes.
`timescale 1ns/10ps
`default_nettype none
`include "adcu_defs.svh"

module adcu_top #(
	parameter int NUM_CHAN = 4,
	parameter int LATENCY  = `ADCU_LATENCY_SAMPLES
) (
	// Clock and reset
	input  wire logic                    mclk,
	input  wire logic                    reset_n,
	// Avalon-MM slave
	input  wire adcu_pkg::adcu_avs_req_s avs_req,
	output logic                         avs_waitrequest,
	output logic [31:0]                  avs_readdata,
	// Noise-shaping control
	input  wire logic                    boost_control_pin,
	output logic [NUM_CHAN-1:0]          boost_en,
	// Configuration outputs
	output logic                         output_swing_ctrl_enable,
	output logic [NUM_CHAN-1:0]          chan_powerdown,
	// Sampling: one-cycle enable per falling edge of the sampling clock
	input  wire logic                    sample_fall_en,
	input  wire adcu_pkg::adcu_sample_t  sample_in [NUM_CHAN],
	// Converted output
	output adcu_pkg::adcu_sample_t       data_out [NUM_CHAN],
	output logic                         data_valid,
	output adcu_pkg::adcu_lane_t         ddr_lane [NUM_CHAN],
	output logic                         ddr_phase
);
	import adcu_pkg::*;

	localparam int NUM_REGS = 12;
	localparam logic [7:0] REG_IDX [NUM_REGS] = '{
		`ADCU_IDX_OFFS_COMP, `ADCU_IDX_TUNE_A, `ADCU_IDX_TUNE_B, `ADCU_IDX_TUNE_C,
		`ADCU_IDX_TUNE_D, `ADCU_IDX_TUNE_E, `ADCU_IDX_BOOST_SRC, `ADCU_IDX_TUNE_UNADDR,
		`ADCU_IDX_SWING, `ADCU_IDX_TUNE_F, `ADCU_IDX_CHAN_PDN, `ADCU_IDX_BOOST_DIS
	};
	localparam logic [7:0] REG_MASK [NUM_REGS] = '{
		`ADCU_MASK_OFFS_COMP, `ADCU_MASK_TUNE_A, `ADCU_MASK_TUNE_B, `ADCU_MASK_TUNE_C,
		`ADCU_MASK_TUNE_D, `ADCU_MASK_TUNE_E, `ADCU_MASK_BOOST_SRC, `ADCU_MASK_TUNE_UNADDR,
		`ADCU_MASK_SWING, `ADCU_MASK_TUNE_F, `ADCU_MASK_CHAN_PDN, `ADCU_MASK_BOOST_DIS
	};
	localparam int SLOT_BOOST_SRC = 6;
	localparam int SLOT_SWING     = 8;
	localparam int SLOT_CHAN_PDN  = 10;
	localparam int SLOT_BOOST_DIS = 11;

	// Bus handshake: every access waits exactly one cycle
	logic             ack_reg;
	logic             req_any;
	logic [7:0]       acc_idx;
	logic [7:0]       regs_reg [NUM_REGS];
	logic [NUM_REGS-1:0] hit;
	logic [7:0]       rd_mux;

	assign req_any         = avs_req.read | avs_req.write;
	assign acc_idx         = avs_req.address[9:2];
	assign avs_waitrequest = req_any & ~ack_reg;

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= req_any & ~ack_reg;
		end
	end

	// Register slots: one writable byte each, fixed-zero bits masked off
	genvar gi;
	generate
		for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
			assign hit[gi] = (acc_idx == REG_IDX[gi]);
			always_ff @(posedge mclk) begin
				if (!reset_n) begin
					regs_reg[gi] <= `ADCU_REG_RESET;
				end else if (avs_req.write && ack_reg && hit[gi] && avs_req.byteenable[0]) begin
					// Masking keeps readback predictable even if the host sets a fixed zero
					regs_reg[gi] <= avs_req.writedata[7:0] & REG_MASK[gi];
				end
			end
		end
	endgenerate

	// Unmapped indices read as zero and ignore writes
	always_comb begin
		rd_mux = 8'h00;
		for (int i = 0; i < NUM_REGS; i++) begin
			if (hit[i]) begin
				rd_mux = regs_reg[i];
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_req.read && !ack_reg) begin
			avs_readdata <= {24'h00_0000, rd_mux};
		end
	end

	// Noise-shaping source select
	logic boost_on;
	always_comb begin
		if (regs_reg[SLOT_BOOST_SRC][`ADCU_BIT_BOOST_SRC]) begin
			boost_on = ~regs_reg[SLOT_BOOST_DIS][`ADCU_BIT_BOOST_DIS];
		end else begin
			boost_on = boost_control_pin;
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			boost_en <= '0;
		end else begin
			boost_en <= {NUM_CHAN{boost_on}};
		end
	end

	// Swing control only for the 11 code; the unused codes leave it off
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			output_swing_ctrl_enable <= 1'b0;
		end else begin
			output_swing_ctrl_enable <=
				(regs_reg[SLOT_SWING][`ADCU_SWING_HI:`ADCU_SWING_LO] == `ADCU_SWING_ON);
		end
	end

	// Channel order A,B,C,D on bits 0..3 of chan_powerdown
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			chan_powerdown <= '0;
		end else begin
			chan_powerdown[0] <= regs_reg[SLOT_CHAN_PDN][`ADCU_BIT_PDN_A];
			chan_powerdown[1] <= regs_reg[SLOT_CHAN_PDN][`ADCU_BIT_PDN_B];
			chan_powerdown[2] <= regs_reg[SLOT_CHAN_PDN][`ADCU_BIT_PDN_C];
			chan_powerdown[3] <= regs_reg[SLOT_CHAN_PDN][`ADCU_BIT_PDN_D];
		end
	end

	// Conversion pipeline, advanced once per sampling-clock fall
	adcu_sample_t pipe_reg [LATENCY][NUM_CHAN];
	logic [$clog2(LATENCY+1)-1:0] fill_reg;

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			fill_reg <= '0;
		end else if (sample_fall_en && fill_reg != LATENCY[$clog2(LATENCY+1)-1:0]) begin
			fill_reg <= fill_reg + 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			data_valid <= 1'b0;
		end else begin
			data_valid <= (fill_reg == LATENCY[$clog2(LATENCY+1)-1:0]);
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			ddr_phase <= 1'b0;
		end else begin
			ddr_phase <= ~ddr_phase;
		end
	end

	genvar gc;
	generate
		for (gc = 0; gc < NUM_CHAN; gc++) begin : g_chan
			always_ff @(posedge mclk) begin
				if (!reset_n) begin
					for (int s = 0; s < LATENCY; s++) begin
						pipe_reg[s][gc] <= '0;
					end
				end else if (sample_fall_en) begin
					// All channels captured on the same enable
					pipe_reg[0][gc] <= chan_powerdown[gc] ? '0 : sample_in[gc];
					for (int s = 1; s < LATENCY; s++) begin
						pipe_reg[s][gc] <= pipe_reg[s-1][gc];
					end
				end
			end

			always_ff @(posedge mclk) begin
				if (!reset_n) begin
					data_out[gc] <= '0;
				end else begin
					data_out[gc] <= pipe_reg[LATENCY-1][gc];
				end
			end

			// Even bits on phase 0, odd bits on phase 1
			always_ff @(posedge mclk) begin
				if (!reset_n) begin
					ddr_lane[gc] <= '0;
				end else if (ddr_phase) begin
					// Loaded one cycle ahead so the word stands while ddr_phase shows its phase
					ddr_lane[gc] <= {data_out[gc][10], data_out[gc][8], data_out[gc][6],
						data_out[gc][4], data_out[gc][2], data_out[gc][0]};
				end else begin
					ddr_lane[gc] <= {1'b0, data_out[gc][9], data_out[gc][7], data_out[gc][5],
						data_out[gc][3], data_out[gc][1]};
				end
			end
		end
	endgenerate

endmodule : adcu_top
`default_nettype wire

// file: adcu_asserts.sv
// Port-level checker for the upper config bank, bound onto adcu_top
`timescale 1ns/10ps
`default_nettype none
`include "adcu_defs.svh"
module adcu_asserts #(
	parameter int NUM_CHAN = 4
) (
	input wire logic                    mclk,
	input wire logic                    reset_n,
	input wire adcu_pkg::adcu_avs_req_s avs_req,
	input wire logic                    avs_waitrequest,
	input wire logic [31:0]             avs_readdata,
	input wire logic                    boost_control_pin,
	input wire logic [NUM_CHAN-1:0]     boost_en,
	input wire logic                    output_swing_ctrl_enable,
	input wire logic [NUM_CHAN-1:0]     chan_powerdown,
	input wire logic                    sample_fall_en,
	input wire adcu_pkg::adcu_sample_t  data_out [NUM_CHAN],
	input wire logic                    data_valid,
	input wire adcu_pkg::adcu_lane_t    ddr_lane [NUM_CHAN],
	input wire logic                    ddr_phase
);
	import adcu_pkg::*;
	logic [3:0]   n_en_reg;
	adcu_sample_t sample_reg;
	always_ff @(posedge mclk) begin
		if (!reset_n)
			n_en_reg <= 4'h0;
		else if (sample_fall_en && n_en_reg != 4'hf)
			n_en_reg <= n_en_reg + 4'h1;
	end
	always_ff @(posedge mclk) begin
		sample_reg <= data_out[0];
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	sequence s_wr(idx);
		avs_req.write && !avs_waitrequest && avs_req.byteenable[0] && avs_req.address[9:2] == idx;
	endsequence
	a_swing_follow: assert property (s_wr(`ADCU_IDX_SWING) |=> ##1
		output_swing_ctrl_enable == ($past(avs_req.writedata[1:0], 2) == 2'b11))
		else $error("swing enable does not follow field");
	a_pdn_map: assert property (s_wr(`ADCU_IDX_CHAN_PDN) |=> ##1
		chan_powerdown == {$past(avs_req.writedata[3:2], 2), $past(avs_req.writedata[0], 2),
		$past(avs_req.writedata[1], 2)}) else $error("power-down bits mapped wrongly");
	a_wait_once: assert property ((avs_req.read || avs_req.write) && avs_waitrequest
		|=> !avs_waitrequest) else $error("waitrequest held too long");
	a_rd_upper: assert property (avs_req.read && !avs_waitrequest |->
		avs_readdata[31:8] == 24'h0) else $error("read data upper bits set");
	a_reset_zero: assert property ($rose(reset_n) |-> chan_powerdown == '0 &&
		!output_swing_ctrl_enable && !data_valid) else $error("outputs not cleared by reset");
	a_valid_lat: assert property ($rose(data_valid) |->
		n_en_reg == `ADCU_LATENCY_SAMPLES) else $error("first result at wrong sample count");
	a_valid_hold: assert property (data_valid |=> data_valid) else $error("valid dropped");
	a_boost_same: assert property (boost_en == '0 || boost_en == '1)
		else $error("boost enables differ between channels");
	a_phase_tog: assert property ($past(reset_n) |-> ddr_phase != $past(ddr_phase))
		else $error("ddr phase did not toggle");
	a_lane_even: assert property ($past(reset_n) && !ddr_phase |-> ddr_lane[0] ==
		{sample_reg[10], sample_reg[8], sample_reg[6], sample_reg[4], sample_reg[2],
		sample_reg[0]}) else $error("even lane bits wrong");
endmodule : adcu_asserts
bind adcu_top adcu_asserts #(.NUM_CHAN(NUM_CHAN)) i_adcu_asserts (.mclk, .reset_n, .avs_req,
	.avs_waitrequest, .avs_readdata, .boost_control_pin, .boost_en,
	.output_swing_ctrl_enable, .chan_powerdown,
	.sample_fall_en, .data_out, .data_valid, .ddr_lane, .ddr_phase);
`default_nettype wire

// file: adcu_src.sv
// Sampling-side model: one fall enable every fourth cycle, ramp per channel
`timescale 1ns/10ps
`default_nettype none
module adcu_src (
	// Clock and reset
	input  wire logic            mclk,
	input  wire logic            reset_n,
	// Samples
	output logic                 sample_fall_en,
	output adcu_pkg::adcu_sample_t sample_in [4]
);
	import adcu_pkg::*;
	logic [1:0]  div_reg;
	logic [10:0] k_reg;
	always_ff @(posedge mclk) begin
		div_reg <= reset_n ? div_reg + 2'h1 : 2'h0;
		if (!reset_n)
			k_reg <= 11'h000;
		else if (sample_fall_en)
			k_reg <= k_reg + 11'h001;
	end
	// All channels share one enable and one count
	assign sample_fall_en = reset_n && div_reg == 2'h3;
	always_comb for (int i = 0; i < 4; i++) sample_in[i] = k_reg + 11'(i * 256);
endmodule : adcu_src
`default_nettype wire

// file: adcu_tb.sv
// Register and sampling tests of the upper config bank
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module adc_upper_config_register_bank_test;
	import adcu_pkg::*;
	logic          mclk = 1'b0, reset_n = 1'b0, pin = 1'b0, sfe, wreq, valid, swing, phase;
	adcu_avs_req_s req = '0;
	logic [31:0]   rdata;
	logic [3:0]    boost, pdn, ep;
	logic [7:0]    q;
	adcu_sample_t  sin [4], dout [4];
	adcu_lane_t    lane [4];
	int            n_mismatch = 0, cmp_count = 0;
	logic [7:0] idx [12] = '{8'hcf, 8'hd4, 8'hd5, 8'hd6, 8'hd7, 8'hdb, 8'hea, 8'hf0, 8'hf1,
		8'hf5, 8'hfe, 8'h44};
	logic [7:0] mask [12] = '{8'h08, 8'h80, 8'h80, 8'h80, 8'h0c, 8'h30, 8'h80, 8'h38, 8'h23,
		8'h42, 8'h0f, 8'h01};
	always #20 mclk = ~mclk;
	adcu_src i_adcu_src (.mclk, .reset_n, .sample_fall_en(sfe), .sample_in(sin));
	adcu_top i_adcu_top (.mclk, .reset_n, .avs_req(req), .avs_waitrequest(wreq),
		.avs_readdata(rdata), .boost_control_pin(pin), .boost_en(boost),
		.output_swing_ctrl_enable(swing), .chan_powerdown(pdn), .sample_fall_en(sfe),
		.sample_in(sin), .data_out(dout), .data_valid(valid), .ddr_lane(lane), .ddr_phase(phase));
	// Request held until the edge that sees waitrequest low
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		logic ws;
		@(posedge mclk);
		req <= '{read: !w, write: w, address: {a, 2'b00}, byteenable: 4'h1, writedata: {24'h0, d}};
		do begin
			@(negedge mclk);
			ws = wreq;
			q = rdata[7:0];
			@(posedge mclk);
		end while (ws !== 1'b0);
		req.read <= 1'b0;
		req.write <= 1'b0;
	endtask : acc
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		acc(1'b0, a, 8'h00);
		`CHK(q, e)
	endtask : rd
	task automatic wt;
		@(posedge mclk);
		@(negedge mclk);
	endtask : wt
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : finish_test
	initial begin
		repeat (5) @(posedge mclk);
		reset_n <= 1'b1;
		foreach (idx[i]) rd(idx[i], 8'h00);
		foreach (idx[i]) begin
			acc(1'b1, idx[i], 8'hff);
			rd(idx[i], mask[i]);
			acc(1'b1, idx[i], 8'h00);
		end
		acc(1'b1, 8'h10, 8'hff);
		rd(8'h10, 8'h00);
		acc(1'b1, 8'hd7, 8'h0c);
		acc(1'b1, 8'hcf, 8'h08);
		rd(8'hd7, 8'h0c);
		$display("register map test done");
		for (int c = 0; c < 4; c++) begin
			acc(1'b1, 8'hf1, c[0] ? 8'h03 : 8'h00);
			wt;
			`CHK(swing, c[0])
		end
		for (int i = 0; i < 8; i++) begin
			@(posedge mclk) pin <= i[0];
			acc(1'b1, 8'h44, {7'h0, i[1]});
			acc(1'b1, 8'hea, {i[2], 7'h0});
			wt;
			`CHK(boost, i[2] ? {4{~i[1]}} : {4{i[0]}})
		end
		$display("swing and boost test done");
		for (int b = 0; b < 5; b++) begin
			ep = 4'(1 << ((b < 2) ? 1 - b : b));
			acc(1'b1, 8'hfe, 8'(1 << b) & 8'h0f);
			wt;
			`CHK(pdn, ep)
			repeat (44) @(posedge mclk);
			do @(negedge mclk); while (sfe !== 1'b1);
			for (int c = 0; c < 4; c++) `CHK(dout[c], ep[c] ? 11'h000 : 11'(sin[c] - 11'h00a))
		end
		$display("power-down and sampling test done");
		acc(1'b1, 8'hfe, 8'h0f);
		@(posedge mclk) reset_n <= 1'b0;
		repeat (2) @(posedge mclk);
		reset_n <= 1'b1;
		rd(8'hfe, 8'h00);
		$display("second reset test done");
		finish_test();
	end
	initial begin
		#200000;
		n_mismatch++;
		finish_test();
	end
endmodule : adc_upper_config_register_bank_test
`default_nettype wire
